// ---- src/gcf_top.sv ----
/*
  gcf_top: gated clock fanout, one selected clock to six gated outputs,
  with an APB register slave for select and enables.

  Register map, 32-bit words at byte addresses:
    CTRL   0x000 read/write
      bit 0      select, 1 routes the test clock, 0 the main clock
      bit 1      common enable, active low
      bits 7:2   per-output enables, active low, one per output
    STATUS 0x004 read only
      bits 5:0   gated outputs before the output stage
      bit 6      latched common enable, active low
      bits 12:7  latched per-output enables, active low
  Unused bits read zero. An unmapped address, or a write to STATUS,
  completes with PSLVERR set and changes nothing.

  Timing, in CORE_CLK edges:
    every access has one wait state: PREADY rises in the second
    access cycle and stands for one cycle
    a clock input level reaches CLK_OUT two edges after it is sampled
    a new enable takes effect from the first high phase after the next
    falling edge of the selected clock
  Reset is synchronous on RSTN low: main clock chosen, every enable off.

  Assumes MAIN_CLK and TEST_CLK are slow levels synchronous to CORE_CLK
  and that a floating test clock input reads low.
*/
// Operation
// - selected clock drives six outputs together
// - enables follow the currently selected clock
// - active-low enables latched on falling edges
// - outputs switch on or off only while low
// - clock path beats enable path, no runts
// - latches arbitrary at power-up; controller sets them
// - idle test clock, when selected, holds all outputs low
// - select defaults low, choosing the main clock
// - disabled output goes low at next fall
// - one common enable plus six individual
`timescale 1ns/100ps
`default_nettype none
module gcf_top #(
  parameter int N = gcf_pkg::NUM_OUT
) (
  input  wire logic         CORE_CLK,
  input  wire logic         RSTN,
  input  wire logic         MAIN_CLK,
  input  wire logic         TEST_CLK,
  input  wire logic         PSEL,
  input  wire logic         PENABLE,
  input  wire logic         PWRITE,
  input  wire logic [11:0]  PADDR,
  input  wire logic [31:0]  PWDATA,
  output var  logic [31:0]  PRDATA,
  output var  logic         PREADY,
  output var  logic         PSLVERR,
  output var  logic [N-1:0] CLK_OUT
);
  gcf_gate_if #(.N(N)) gi ();

  // control register and its next values
  logic         sel;
  logic         cen_n;
  logic [N-1:0] en_n;
  logic         next_sel;
  logic         next_cen_n;
  logic [N-1:0] next_en_n;

  // sampled clock inputs and the falling-edge detector
  logic         main_q;
  logic         test_q;
  logic         prev_level;
  logic         next_main_q;
  logic         next_test_q;
  logic         next_prev_level;
  logic         level;

  // bus response
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic [31:0]  next_prdata;
  logic         next_pready;
  logic         next_pslverr;
  logic         hit_ctrl;
  logic         hit_stat;
  logic         wr_done;

  // output stage
  logic [N-1:0] clk_out;
  logic [N-1:0] next_clk_out;

  // both inputs are sampled on every edge, so a change of select never
  // picks up a stale copy of the newly chosen source
  always_comb begin
    next_main_q     = MAIN_CLK;
    next_test_q     = TEST_CLK;
    next_prev_level = level;
  end

  // input multiplexer; pulldown on an open test input keeps outputs low.
  // a select change acts at once: switching while the old source is high
  // and the new one low ends that high phase early, so software should
  // switch while both sources are low
  assign level = sel ? test_q : main_q;

  assign gi.clk_level = level;
  assign gi.clk_fall  = prev_level & ~level;
  assign gi.cen_n     = cen_n;
  assign gi.en_n      = en_n;

  gcf_gate #(.N(N)) u_gate (
    .CORE_CLK (CORE_CLK),
    .RSTN     (RSTN),
    .gi       (gi)
  );

  // address decode and the edge at which a transfer completes
  assign hit_ctrl = (PADDR == gcf_pkg::OFS_CTRL);
  assign hit_stat = (PADDR == gcf_pkg::OFS_STATUS);
  assign wr_done  = PSEL & PENABLE & pready & PWRITE & hit_ctrl;

  // control register; write lands on the edge that samples pready high
  always_comb begin
    next_sel   = sel;
    next_cen_n = cen_n;
    next_en_n  = en_n;
    if (wr_done) begin
      next_sel   = PWDATA[gcf_pkg::CTRL_SEL_BIT];
      next_cen_n = PWDATA[gcf_pkg::CTRL_CEN_BIT];
      next_en_n  = PWDATA[gcf_pkg::CTRL_EN_LSB +: N];
    end
  end

  // one wait state: pready rises in the second access cycle
  always_comb begin
    next_pready  = PSEL & PENABLE & ~pready;
    next_pslverr = 1'b0;
    next_prdata  = 32'h0000_0000;
    if (next_pready) begin
      if (hit_ctrl) begin
        next_prdata[gcf_pkg::CTRL_SEL_BIT]       = sel;
        next_prdata[gcf_pkg::CTRL_CEN_BIT]       = cen_n;
        next_prdata[gcf_pkg::CTRL_EN_LSB +: N]   = en_n;
      end else if (hit_stat) begin
        next_prdata[gcf_pkg::STAT_Q_LSB +: N]    = gi.q;
        next_prdata[gcf_pkg::STAT_CEN_BIT]       = gi.cen_q_n;
        next_prdata[gcf_pkg::STAT_EN_LSB +: N]   = gi.en_q_n;
      end else begin
        next_pslverr = 1'b1;               // unmapped: error, data zero
      end
      if (PWRITE && hit_stat) begin
        next_pslverr = 1'b1;               // status is read only
      end
    end
  end

  // sampled inputs reset low, the idle level of both sources, so the
  // edge detector sees no false falling edge right after reset
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      main_q     <= 1'b0;
      test_q     <= 1'b0;
      prev_level <= 1'b0;
    end else begin
      main_q     <= next_main_q;
      test_q     <= next_test_q;
      prev_level <= next_prev_level;
    end
  end

  // select reset low so the main clock is chosen by default
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      sel   <= gcf_pkg::RST_SEL;
      cen_n <= gcf_pkg::RST_CEN_N;
      en_n  <= gcf_pkg::RST_EN_N;
    end else begin
      sel   <= next_sel;
      cen_n <= next_cen_n;
      en_n  <= next_en_n;
    end
  end

  // bus response; each field stands for the one cycle of pready
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // output stage: one more register so every output leaves a flip-flop;
  // it costs an edge of latency but keeps the six outputs aligned
  always_comb begin
    next_clk_out = gi.q;
  end

  // outputs held low in reset, whatever the latches hold later
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      clk_out <= '0;
    end else begin
      clk_out <= next_clk_out;
    end
  end

  // ports come straight from the registers above
  assign PRDATA  = prdata;
  assign PREADY  = pready;
  assign PSLVERR = pslverr;
  assign CLK_OUT = clk_out;
endmodule
`default_nettype wire

// ---- src/gcf_pkg.sv ----
/*
  gcf_pkg: register offsets, field positions and reset values of the
  gated clock fanout block.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package gcf_pkg;
  localparam int          NUM_OUT        = 6;
  localparam logic [11:0] OFS_CTRL       = 12'h000;
  localparam logic [11:0] OFS_STATUS     = 12'h004;
  // control register fields
  localparam int          CTRL_SEL_BIT   = 0;
  localparam int          CTRL_CEN_BIT   = 1;
  localparam int          CTRL_EN_LSB    = 2;
  // status register fields
  localparam int          STAT_Q_LSB     = 0;
  localparam int          STAT_CEN_BIT   = 6;
  localparam int          STAT_EN_LSB    = 7;
  // values after reset: main clock chosen, every enable deasserted
  localparam logic        RST_SEL        = 1'b0;
  localparam logic        RST_CEN_N      = 1'b1;
  localparam logic [5:0]  RST_EN_N       = 6'h3F;
endpackage

// ---- src/gcf_gate_if.sv ----
/*
  gcf_gate_if: carries the selected clock, its falling-edge strobe, the
  raw enables and the gated outputs between the top and the gate stage.
  Assumes one clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
interface gcf_gate_if #(parameter int N = 6);
  logic         clk_level;   // selected clock, sampled
  logic         clk_fall;    // one-cycle strobe on its falling edge
  logic         cen_n;       // common enable from software
  logic [N-1:0] en_n;        // per-output enables from software
  logic         cen_q_n;     // latched common enable
  logic [N-1:0] en_q_n;      // latched per-output enables
  logic [N-1:0] q;           // gated outputs

  modport src (output clk_level, output clk_fall, output cen_n, output en_n,
               input cen_q_n, input en_q_n, input q);
  modport gate (input clk_level, input clk_fall, input cen_n, input en_n,
                output cen_q_n, output en_q_n, output q);
endinterface
`default_nettype wire

// ---- src/gcf_gate.sv ----
/*
  gcf_gate: enable latches and output gating of the fanout.
  Assumes clk_fall marks a cycle in which clk_level has just gone low.
*/
`timescale 1ns/100ps
`default_nettype none
module gcf_gate #(
  parameter int N = 6
) (
  input  wire logic CORE_CLK,
  input  wire logic RSTN,
  gcf_gate_if.gate  gi
);
  logic         cen_q_n;
  logic [N-1:0] en_q_n;
  logic [N-1:0] q;
  logic         next_cen_q_n;
  logic [N-1:0] next_en_q_n;
  logic [N-1:0] next_q;

  // enables are taken only at a falling edge, so the output is already low
  always_comb begin
    next_cen_q_n = cen_q_n;
    next_en_q_n  = en_q_n;
    if (gi.clk_fall) begin
      next_cen_q_n = gi.cen_n;
      next_en_q_n  = gi.en_n;
    end
  end

  // per-output gating; uses the latches as they stood before this edge,
  // so a disable never cuts the high phase in progress
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_out
      assign next_q[i] = gi.clk_level & ~cen_q_n & ~en_q_n[i];
    end
  endgenerate

  // latch state after reset stands for the undefined power-up state
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      cen_q_n <= gcf_pkg::RST_CEN_N;
      en_q_n  <= gcf_pkg::RST_EN_N;
      q       <= '0;
    end else begin
      cen_q_n <= next_cen_q_n;
      en_q_n  <= next_en_q_n;
      q       <= next_q;
    end
  end

  assign gi.cen_q_n = cen_q_n;
  assign gi.en_q_n  = en_q_n;
  assign gi.q       = q;
endmodule
`default_nettype wire

// ---- tb/gcf_asserts.sv ----
/* gcf_asserts: port checks of gcf_top, bound after the module.
   Assumes every port is sampled on CORE_CLK, RSTN low resets. */
`timescale 1ns/100ps
`default_nettype none
module gcf_asserts #(parameter int N = 6) (
  input wire logic         CORE_CLK,
  input wire logic         RSTN,
  input wire logic         MAIN_CLK,
  input wire logic         TEST_CLK,
  input wire logic         PSEL,
  input wire logic         PENABLE,
  input wire logic         PWRITE,
  input wire logic [11:0]  PADDR,
  input wire logic [31:0]  PWDATA,
  input wire logic [31:0]  PRDATA,
  input wire logic         PREADY,
  input wire logic         PSLVERR,
  input wire logic [N-1:0] CLK_OUT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  // pending access; both sources quiet long enough to flush the pipe
  sequence s_acc; PSEL && PENABLE && !PREADY; endsequence
  sequence s_quiet; (!MAIN_CLK && !TEST_CLK) [*4]; endsequence
  AST_ANSWER: assert property (s_acc |=> PREADY)
    else $error("no answer after access");
  AST_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  AST_NOREQ: assert property (!(PSEL && PENABLE) |=> !PREADY)
    else $error("ready without access");
  AST_UNMAPPED: assert property (PREADY && PADDR > 12'h004 |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access not refused");
  AST_RO: assert property (PREADY && PWRITE && PADDR == 12'h004 |-> PSLVERR)
    else $error("status write not refused");
  AST_HIGH_PHASE: assert property (
    CLK_OUT != 0 && $past(CLK_OUT) != 0 |-> CLK_OUT == $past(CLK_OUT))
    else $error("output set changed inside a high phase");
  AST_SOURCE: assert property (
    CLK_OUT != 0 |-> $past(MAIN_CLK, 3) || $past(TEST_CLK, 3))
    else $error("output high without a high source");
  AST_QUIET: assert property (s_quiet |-> CLK_OUT == 0)
    else $error("output high with both sources quiet");
endmodule
bind gcf_top gcf_asserts #(.N(N)) chk_u (
  .CORE_CLK (CORE_CLK),
  .RSTN     (RSTN),
  .MAIN_CLK (MAIN_CLK),
  .TEST_CLK (TEST_CLK),
  .PSEL     (PSEL),
  .PENABLE  (PENABLE),
  .PWRITE   (PWRITE),
  .PADDR    (PADDR),
  .PWDATA   (PWDATA),
  .PRDATA   (PRDATA),
  .PREADY   (PREADY),
  .PSLVERR  (PSLVERR),
  .CLK_OUT  (CLK_OUT)
);
`default_nettype wire

// ---- tb/gcf_clk_src.sv ----
/* gcf_clk_src: main and test clock sources as slow levels.
   Assumes CORE_CLK runs free; a stopped source reads low. */
`timescale 1ns/100ps
`default_nettype none
module gcf_clk_src (
  input  wire logic CORE_CLK,
  input  wire logic run_main,
  input  wire logic run_test,
  output var  logic MAIN_CLK = 1'b0,
  output var  logic TEST_CLK = 1'b0
);
  logic [3:0] cnt = 4'h0;
  // main period 4 cycles, test 8; stopped inputs held low
  always @(posedge CORE_CLK) begin
    cnt <= cnt + 4'h1;
    MAIN_CLK <= run_main & cnt[1];
    TEST_CLK <= run_test & cnt[2];
  end
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
/* tb_top: table of control settings plus hand tests for gcf_top.
   Assumes only the APB handshake; every transfer waits for PREADY. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        core_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, run_main = 1'b1, run_test = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, main_clk, test_clk;
  logic [5:0]  clk_out, seen;
  int          n_errors = 0, check_count = 0;
  // ctrl, run main, run test, outputs that must toggle
  logic [15:0] rows [8] = '{16'h00FF, 16'h02C0, 16'hA8D5, 16'hF8C1,
                            16'h01FF, 16'h0100, 16'h017F, 16'h0040};
  always #20 core_clk = ~core_clk;
  gcf_clk_src src_u (.CORE_CLK(core_clk), .run_main(run_main), .run_test(run_test),
                     .MAIN_CLK(main_clk), .TEST_CLK(test_clk));
  gcf_top dut_u (.CORE_CLK(core_clk), .RSTN(rstn), .MAIN_CLK(main_clk),
    .TEST_CLK(test_clk), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CLK_OUT(clk_out));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one APB transfer, entered just after an edge; idle edge at the end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk) penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hang
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // collect which outputs go high once the latches settle
  task automatic watch(output logic [5:0] m);
    m = 6'h00;
    repeat (16) @(posedge core_clk);
    repeat (32) begin
      @(posedge core_clk);
      m = m | clk_out;
    end
  endtask
  task automatic close_out;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // tests take about 570 cycles; 5000 cycles leave a wide margin
  initial begin
    #200us;
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    close_out();
  end
  initial begin
    repeat (10) @(posedge core_clk);
    chk({26'h0, clk_out}, 32'h0);
    rstn <= 1'b1;
    @(posedge core_clk);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h000000FE);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h00001FC0);
    foreach (rows[i]) begin
      run_main <= rows[i][7];
      run_test <= rows[i][6];
      apb(1'b1, 12'h000, {24'h0, rows[i][15:8]});
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, {24'h0, rows[i][15:8]});
      watch(seen);
      chk({26'h0, seen}, {26'h0, rows[i][5:0]});
      apb(1'b0, 12'h004, 32'h0);
      chk({25'h0, rd[12:6]}, {25'h0, rows[i][15:9]});
    end
    apb(1'b1, 12'h008, 32'hFFFFFFFF);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, 12'h004, 32'h0);
    chk({31'h0, err}, 32'h1);
    // refused writes must leave the control word as the last row set it
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h00000000);
    // mid-run reset with the main clock running: main chosen, all off
    run_main <= 1'b1;
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk({26'h0, clk_out}, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h000000FE);
    watch(seen);
    chk({26'h0, seen}, 32'h0);
    close_out();
  end
endmodule
`default_nettype wire
